//--- dv/srl_status_assertions.sv
// Checker for the serial link and the device's status outputs.
// Assumes the bench wires it beside the interface that joins both ends.
`timescale 1ns/1ps
`default_nettype none

module srl_status_assertions (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       si,
  input wire logic [7:0] status_byte_one,
  input wire logic [7:0] status_byte_two,
  input wire logic [7:0] status_byte_three,
  input wire logic [7:0] status_byte_four,
  input wire logic [7:0] status_byte_five,
  input wire logic       regs_locked
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Chip select rising at the end of a frame
  sequence s_release;
    !cs_n ##1 cs_n;
  endsequence

  // Well inside a frame, long past any earlier judgement
  sequence s_mid_frame;
    (!cs_n) [*5];
  endsequence

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock moved while deselected");
  // Data only moves while the link clock is low, so the device samples a settled bit
  a_si_held_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("serial data moved while link clock high");
  a_cs_gap_held: assert property (s_release |-> cs_n [*6])
    else $error("chip select high time too short");
  a_frame_no_change: assert property (s_mid_frame |-> $stable({status_byte_one,
    status_byte_two, status_byte_three, status_byte_four, status_byte_five}))
    else $error("status changed in mid frame");
  // Changes only land once the release has been seen
  a_change_at_release: assert property ($changed({status_byte_one, status_byte_two,
    status_byte_three, status_byte_four, status_byte_five, regs_locked})
    |-> cs_n && $past(cs_n, 2))
    else $error("status changed without a release");
  a_lock_guarded: assert property ($rose(regs_locked) |->
    $past(status_byte_one[srl_pkg::PSL_BIT]) && $past(status_byte_two[srl_pkg::PSH_BIT])
    && $past(status_byte_one[srl_pkg::WEL_BIT]))
    else $error("lock taken without protect bits and latch");
  a_lock_clears_latch: assert property ($rose(regs_locked) |->
    !status_byte_one[srl_pkg::WEL_BIT])
    else $error("latch still set after lock");
  a_lock_sticky: assert property (regs_locked |=> regs_locked)
    else $error("lock dropped without reset");
  // Only the latch may still move once locked
  a_locked_frozen: assert property (regs_locked && $past(regs_locked) |->
    $stable({status_byte_one[7:2], status_byte_one[0], status_byte_two,
    status_byte_three, status_byte_four, status_byte_five}))
    else $error("locked status bytes changed");
endmodule

`default_nettype wire

//--- dv/status_register_write_lock_tb_top.sv
// Bench: host end drives device end through the serial interface.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

module status_register_write_lock_tb_top;
  localparam int W = srl_pkg::WEL_BIT;  // Latch position in byte one

  logic        mclk;             // Core clock, 50 MHz
  logic        rst_n;            // Async reset, active low
  logic [7:0]  addr;             // Host port address
  logic [31:0] wdata;            // Host port write data
  logic        wr;               // Write strobe
  logic        rd;               // Read strobe
  logic [31:0] rdata;            // Read data, one cycle after rd
  logic [7:0]  sb [1:5];         // Status bytes seen at the device
  logic [7:0]  ex [1:5];         // Expected status bytes
  logic        regs_locked;      // Lock state
  logic        volatile_enable;  // Pending volatile enable
  logic [31:0] rv;               // Last read value
  int          fails;            // Mismatch count
  int          tests_run;        // Comparison count
  int          nfr;              // Frames sent
  // Data per indirect address; keeps both protect bits set for the lock
  logic [7:0]  dat [1:5] = '{8'hC1, 8'h81, 8'hA5, 8'h3C, 8'h99};
  logic [7:0]  bad [3] = '{8'h00, 8'h06, 8'hFF};  // Unmapped addresses

  srl_spi_if u_srl_spi_if ();

  srl_host u_srl_host (
    .mclk  (mclk),
    .rst_n (rst_n),
    .addr  (addr),
    .wdata (wdata),
    .wr    (wr),
    .rd    (rd),
    .rdata (rdata),
    .spi   (u_srl_spi_if)
  );

  srl_device u_srl_device (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .spi               (u_srl_spi_if),
    .status_byte_one   (sb[1]),
    .status_byte_two   (sb[2]),
    .status_byte_three (sb[3]),
    .status_byte_four  (sb[4]),
    .status_byte_five  (sb[5]),
    .regs_locked       (regs_locked),
    .volatile_enable   (volatile_enable)
  );

  srl_status_assertions u_srl_status_assertions (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .cs_n              (u_srl_spi_if.cs_n),
    .sck               (u_srl_spi_if.sck),
    .si                (u_srl_spi_if.si),
    .status_byte_one   (sb[1]),
    .status_byte_two   (sb[2]),
    .status_byte_three (sb[3]),
    .status_byte_four  (sb[4]),
    .status_byte_five  (sb[5]),
    .regs_locked       (regs_locked)
  );

  // Core clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // One write cycle on the host port
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // One read cycle; data only stands in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // Sends one frame, then waits for the device to judge it
  task automatic frame(input logic [2:0] n, input logic [2:0] tail, input logic [7:0] b0,
                       input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00);
    int k;
    wr_reg(srl_pkg::HOST_BYTE0, {24'h0, b0});
    wr_reg(8'h08, {24'h0, b1});
    wr_reg(8'h0C, {24'h0, b2});
    wr_reg(srl_pkg::HOST_CTRL, {25'h0, tail, 1'b0, n});
    k = 0;
    rv = 32'h1;
    // Bounded poll of busy
    while (rv[0] !== 1'b0 && k < 500)
    begin
      rd_reg(srl_pkg::HOST_STATUS);
      k++;
    end
    // A host that never goes idle counts as a mismatch
    if (k >= 500)
    begin
      fails++;
      $display("[ERR] busy poll exp=0 got=%0h", rv[0]);
    end
    repeat (6) @(posedge mclk);
    nfr++;
  endtask

  // Write enable frame
  task automatic wren();
    frame(1, 0, srl_pkg::OP_WREN);
    ex[1][W] = 1'b1;
  endtask

  // All five status bytes against the expectation
  task automatic chk5();
    for (int i = 1; i <= 5; i++)
      `CHK("status byte", ex[i], sb[i])
  endtask

  // Verdict; the only place the run ends
  task automatic conclude();
    $display("Checks: %0d, mismatches: %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial
  begin
    #1000000;
    fails++;
    $display("[ERR] watchdog exp=done got=timeout");
    conclude();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fails = 0;
    tests_run = 0;
    nfr = 0;
    for (int i = 1; i <= 5; i++)
      ex[i] = srl_pkg::STATUS_RESET;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk5();
    rd_reg(8'h3C);
    `CHK("unmapped read", 32'h0, rv)
    frame(2, 0, srl_pkg::OP_WR_ONE, 8'hAA);
    chk5();
    // Good keys but protect bits clear
    wren();
    frame(3, 0, srl_pkg::OP_LOCK, srl_pkg::LOCK_KEY_FIRST, srl_pkg::LOCK_KEY_SECOND);
    ex[1][W] = 1'b0;
    `CHK("lock early", 1'b0, regs_locked)
    wren();
    chk5();
    frame(2, 0, srl_pkg::OP_WR_THREE, 8'h5A);
    ex[3] = 8'h5A;
    ex[1][W] = 1'b0;
    chk5();
    wren();
    frame(3, 0, srl_pkg::OP_WR_ONE, 8'h81, 8'h01);
    ex[1] = 8'h81;
    ex[2] = 8'h01;
    chk5();
    `CHK("bits alone", 1'b0, regs_locked)
    // Three stray clocks: nothing moves, latch kept
    wren();
    frame(2, 3, srl_pkg::OP_WR_TWO, 8'hC3);
    chk5();
    // Host keeps the last frame's setup readable
    rd_reg(srl_pkg::HOST_CTRL);
    `CHK("ctrl readback", 32'h0000_0032, rv)
    rd_reg(8'h08);
    `CHK("byte readback", 32'h0000_00C3, rv)
    frame(2, 0, srl_pkg::OP_WR_TWO, 8'hC3);
    ex[2] = 8'hC3;
    ex[1][W] = 1'b0;
    chk5();
    frame(1, 0, srl_pkg::OP_VOLEN);
    `CHK("vol pending", 1'b1, volatile_enable)
    chk5();
    frame(3, 0, srl_pkg::OP_WR_IND, 8'h04, 8'h77);
    ex[4] = 8'h77;
    `CHK("vol used", 1'b0, volatile_enable)
    chk5();
    for (int i = 1; i <= 5; i++)
    begin
      wren();
      frame(3, 0, srl_pkg::OP_WR_IND, 8'(i), dat[i]);
      ex[i] = dat[i];
      ex[1][W] = 1'b0;
      chk5();
    end
    foreach (bad[j])
    begin
      wren();
      frame(3, 0, srl_pkg::OP_WR_IND, bad[j], 8'h00);
      ex[1][W] = 1'b0;
      chk5();
    end
    wren();
    frame(4, 0, srl_pkg::OP_WR_IND, 8'h03, 8'h11);
    ex[1][W] = 1'b0;
    chk5();
    frame(3, 0, srl_pkg::OP_WR_IND, 8'h03, 8'h11);
    chk5();
    wren();
    frame(3, 0, srl_pkg::OP_LOCK, srl_pkg::LOCK_KEY_SECOND, srl_pkg::LOCK_KEY_FIRST);
    ex[1][W] = 1'b0;
    `CHK("keys swapped", 1'b0, regs_locked)
    frame(3, 0, srl_pkg::OP_LOCK, srl_pkg::LOCK_KEY_FIRST, srl_pkg::LOCK_KEY_SECOND);
    `CHK("no latch", 1'b0, regs_locked)
    wren();
    frame(3, 0, srl_pkg::OP_LOCK, srl_pkg::LOCK_KEY_FIRST, srl_pkg::LOCK_KEY_SECOND);
    ex[1][W] = 1'b0;
    `CHK("locked", 1'b1, regs_locked)
    wren();
    frame(2, 0, srl_pkg::OP_WR_THREE, 8'h00);
    ex[1][W] = 1'b0;
    chk5();
    // A zero length start is refused, so the host stays idle
    wr_reg(srl_pkg::HOST_CTRL, 32'h0000_0000);
    rd_reg(srl_pkg::HOST_STATUS);
    `CHK("frame count", {23'h0, 8'(nfr), 1'b0}, rv)
    // Reset in mid-run is the only way out of the lock
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 1; i <= 5; i++)
      ex[i] = srl_pkg::STATUS_RESET;
    `CHK("lock after reset", 1'b0, regs_locked)
    `CHK("vol after reset", 1'b0, volatile_enable)
    chk5();
    // One data byte after 01h leaves byte two alone; latch bit forced low
    wren();
    frame(2, 0, srl_pkg::OP_WR_ONE, 8'h83);
    ex[1] = 8'h81;
    chk5();
    conclude();
  end
endmodule

`default_nettype wire

//--- rtl/srl_device.sv
// Device end: status byte write, indirect write and lock handling.
// Assumes the host keeps sck low while chip select is high, and keeps
// chip select high for at least six mclk cycles between frames.
`timescale 1ns/1ps
`default_nettype none

module srl_device (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  srl_spi_if.dev     spi,
  output logic [7:0] status_byte_one,
  output logic [7:0] status_byte_two,
  output logic [7:0] status_byte_three,
  output logic [7:0] status_byte_four,
  output logic [7:0] status_byte_five,
  output logic       regs_locked,
  output logic       volatile_enable
);

  // Link side state, clocked by sck
  typedef struct packed {
    logic [2:0] bitcnt;  // Bits of the current byte
    logic [2:0] nbytes;  // Whole bytes, saturating
    logic [6:0] shift;   // Partial byte
    logic [7:0] op;      // Byte 0
    logic [7:0] arg1;    // Byte 1
    logic [7:0] arg2;    // Byte 2
  } srl_link_t;

  // Core side state, clocked by mclk
  typedef struct packed {
    logic                                   cs_s1;   // Sync stage one
    logic                                   cs_s2;   // Sync stage two
    logic                                   cs_d;    // Delayed for edge
    logic                                   clr;     // Clears link side
    logic [srl_pkg::NUM_STATUS-1:0][7:0]    sr;      // Status bytes
    logic                                   vol;     // Pending volatile enable
    logic                                   locked;  // Status bytes locked
  } srl_core_t;

  srl_link_t l_r;        // Link registers
  srl_link_t l_nxt;      // Link next value
  srl_core_t m_r;        // Core registers
  srl_core_t m_nxt;      // Core next value
  logic      link_rst_n; // Link side reset, from flops only

  // Write permission: some enable present and not locked
  function automatic logic may_write(input logic write_enable_latch, input logic vol,
                                     input logic locked);
    may_write = (write_enable_latch | vol) & ~locked;
  endfunction

  // Valid indirect address window
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a >= srl_pkg::IND_ADDR_FIRST) && (a <= srl_pkg::IND_ADDR_LAST);
  endfunction

  // Link side is cleared by the core once a frame has been judged, so
  // the next frame starts at bit zero without needing a sck edge.
  assign link_rst_n = rst_n & ~m_r.clr;

  // Link side next state: shift bits in on rising sck
  always_comb
  begin
    l_nxt = l_r;
    l_nxt.bitcnt = l_r.bitcnt + 3'h1;
    l_nxt.shift  = {l_r.shift[5:0], spi.si};
    if (l_r.bitcnt == 3'h7)
    begin
      // Byte complete, MSB arrived first
      case (l_r.nbytes)
        3'h0: l_nxt.op   = {l_r.shift, spi.si};
        3'h1: l_nxt.arg1 = {l_r.shift, spi.si};
        3'h2: l_nxt.arg2 = {l_r.shift, spi.si};
        default: ;                                 // Later bytes only counted
      endcase
      // Saturate so long frames stay recognisable as too long
      if (l_r.nbytes != 3'h7)
      begin
        l_nxt.nbytes = l_r.nbytes + 3'h1;
      end
    end
  end

  // Link side registers
  always_ff @(posedge spi.sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      l_r <= '0;
    end
    else
    begin
      l_r <= l_nxt;
    end
  end

  // Core next state: judge the frame when chip select rises.
  // Link fields are read only after the release is synchronised, when
  // sck has stopped, so they are static at this moment.
  always_comb
  begin
    logic       rise;    // Chip select release seen
    logic       whole;   // Ended on a byte boundary
    logic       write_enable_latch;     // Current latch value
    logic [2:0] idx;     // Indirect target index
    rise  = 1'b0;
    whole = 1'b0;
    write_enable_latch   = 1'b0;
    idx   = 3'h0;
    m_nxt = m_r;
    m_nxt.cs_s1 = spi.cs_n;
    m_nxt.cs_s2 = m_r.cs_s1;
    m_nxt.cs_d  = m_r.cs_s2;
    m_nxt.clr   = 1'b0;
    rise  = m_r.cs_s2 & ~m_r.cs_d;
    whole = (l_r.bitcnt == 3'h0) && (l_r.nbytes != 3'h0);
    write_enable_latch   = m_r.sr[0][srl_pkg::WEL_BIT];
    idx   = l_r.arg1[2:0] - 3'h1;
    if (rise)
    begin
      m_nxt.clr = 1'b1;
      if (whole)
      begin
        case (l_r.op)
          // Write enable: only as a lone opcode
          srl_pkg::OP_WREN:
          begin
            if (l_r.nbytes == 3'h1)
            begin
              m_nxt.sr[0][srl_pkg::WEL_BIT] = 1'b1;
            end
          end
          // Volatile enable: latch left alone
          srl_pkg::OP_VOLEN:
          begin
            if (l_r.nbytes == 3'h1)
            begin
              m_nxt.vol = 1'b1;
            end
          end
          // Byte one, optionally byte two as well
          srl_pkg::OP_WR_ONE:
          begin
            if ((l_r.nbytes == 3'h2) || (l_r.nbytes == 3'h3))
            begin
              if (may_write(write_enable_latch, m_r.vol, m_r.locked))
              begin
                m_nxt.sr[0] = l_r.arg1;
                if (l_r.nbytes == 3'h3)
                begin
                  m_nxt.sr[1] = l_r.arg2;
                end
              end
              m_nxt.sr[0][srl_pkg::WEL_BIT] = 1'b0;
              m_nxt.vol = 1'b0;
            end
          end
          // Byte two or three, exactly one data byte
          srl_pkg::OP_WR_TWO, srl_pkg::OP_WR_THREE:
          begin
            if (l_r.nbytes == 3'h2)
            begin
              if (may_write(write_enable_latch, m_r.vol, m_r.locked))
              begin
                if (l_r.op == srl_pkg::OP_WR_TWO)
                begin
                  m_nxt.sr[1] = l_r.arg1;
                end
                else
                begin
                  m_nxt.sr[2] = l_r.arg1;
                end
              end
              m_nxt.sr[0][srl_pkg::WEL_BIT] = 1'b0;
              m_nxt.vol = 1'b0;
            end
          end
          // Indirect write: opcode, address, one data byte
          srl_pkg::OP_WR_IND:
          begin
            if (l_r.nbytes >= 3'h2)
            begin
              // Exactly three bytes, valid address, enabled
              if ((l_r.nbytes == 3'h3) && addr_ok(l_r.arg1) &&
                  may_write(write_enable_latch, m_r.vol, m_r.locked))
              begin
                m_nxt.sr[idx] = l_r.arg2;
              end
              // Any whole indirect frame of two bytes or more drops the latch
              m_nxt.sr[0][srl_pkg::WEL_BIT] = 1'b0;
              m_nxt.vol = 1'b0;
            end
          end
          // Lock: two keys, latch set, both protect bits set
          srl_pkg::OP_LOCK:
          begin
            if (l_r.nbytes == 3'h3)
            begin
              if ((l_r.arg1 == srl_pkg::LOCK_KEY_FIRST) &&
                  (l_r.arg2 == srl_pkg::LOCK_KEY_SECOND) &&
                  write_enable_latch &&
                  m_r.sr[0][srl_pkg::PSL_BIT] &&
                  m_r.sr[1][srl_pkg::PSH_BIT])
              begin
                m_nxt.locked = 1'b1;
              end
              m_nxt.sr[0][srl_pkg::WEL_BIT] = 1'b0;
            end
          end
          // Other opcodes are not handled here
          default: ;
        endcase
      end
    end
  end

  // Core registers; chip select idles high
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m_r.cs_s1  <= 1'b1;
      m_r.cs_s2  <= 1'b1;
      m_r.cs_d   <= 1'b1;
      m_r.clr    <= 1'b0;
      m_r.sr     <= {srl_pkg::NUM_STATUS{srl_pkg::STATUS_RESET}};
      m_r.vol    <= 1'b0;
      m_r.locked <= 1'b0;
    end
    else
    begin
      m_r <= m_nxt;
    end
  end

  // Outputs straight from core flops
  assign status_byte_one   = m_r.sr[0];
  assign status_byte_two   = m_r.sr[1];
  assign status_byte_three = m_r.sr[2];
  assign status_byte_four  = m_r.sr[3];
  assign status_byte_five  = m_r.sr[4];
  assign regs_locked       = m_r.locked;
  assign volatile_enable   = m_r.vol;

endmodule

`default_nettype wire

//--- rtl/srl_host.sv
// Host end: builds single-line SPI frames from a small command port.
// Assumes software writes the frame bytes before starting a frame.
`timescale 1ns/1ps
`default_nettype none

module srl_host #(
  parameter int HALF_CYC = srl_pkg::SCK_HALF_CYC,  // mclk cycles per sck half
  parameter int GAP_CYC  = srl_pkg::CS_GAP_CYC     // chip select high time
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  srl_spi_if.host          spi
);

  // Refuse timings the counter cannot hold or the device cannot follow
  if (HALF_CYC < 1 || HALF_CYC > 255 || GAP_CYC < 6 || GAP_CYC > 255)
  begin : g_bad_param
    $error("srl_host: timing parameter out of range");
  end

  // Frame sequencer states
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL, H_GAP} srl_hst_t;

  // All host state
  typedef struct packed {
    srl_hst_t                           st;      // Sequencer state
    logic [7:0]                         cnt;     // Timing down-counter
    logic [5:0]                         bits;    // Clocks still to send
    logic [31:0]                        shreg;   // Outgoing bits, MSB first
    logic [srl_pkg::HOST_BYTES-1:0][7:0] bytes;  // Frame bytes
    logic [2:0]                         len;     // Bytes in frame
    logic [2:0]                         tail;    // Extra odd clocks
    logic [7:0]                         frames;  // Finished frames
    logic                               cs_n;    // Chip select pin
    logic                               sck;     // Link clock pin
    logic                               si;      // Data pin
    logic [31:0]                        rdata;   // Read answer
  } srl_host_st_t;

  localparam logic [7:0] HALF_C = 8'(HALF_CYC - 1);  // Counter reload
  localparam logic [7:0] GAP_C  = 8'(GAP_CYC - 1);   // Counter reload

  srl_host_st_t h_r;    // Registers
  srl_host_st_t h_nxt;  // Next value

  // Next state: command port and frame sequencer
  always_comb
  begin
    logic [2:0] wlen;   // Requested byte count
    logic [2:0] bsel;   // Byte register index
    wlen  = wdata[srl_pkg::CTRL_LEN_LSB +: 3];
    bsel  = 3'((addr - srl_pkg::HOST_BYTE0) >> 2);
    h_nxt = h_r;
    h_nxt.rdata = 32'h0000_0000;
    // Register writes; frame bytes are writable any time
    if (wr)
    begin
      if ((addr >= srl_pkg::HOST_BYTE0) && (addr < srl_pkg::HOST_STATUS) &&
          (addr[1:0] == 2'h0))
      begin
        h_nxt.bytes[bsel[1:0]] = wdata[7:0];
      end
      // Start only when idle and the length is sane; a busy host
      // ignores it so a frame is never cut short
      else if ((addr == srl_pkg::HOST_CTRL) && (h_r.st == H_IDLE) &&
               (wlen != 3'h0) && (wlen <= 3'(srl_pkg::HOST_BYTES)))
      begin
        h_nxt.len   = wlen;
        h_nxt.tail  = wdata[srl_pkg::CTRL_TAIL_LSB +: 3];
        h_nxt.bits  = {wlen, 3'h0} + {3'h0, wdata[srl_pkg::CTRL_TAIL_LSB +: 3]};
        h_nxt.shreg = {h_r.bytes[0], h_r.bytes[1], h_r.bytes[2], h_r.bytes[3]};
        h_nxt.si    = h_r.bytes[0][7];
        h_nxt.cs_n  = 1'b0;
        h_nxt.cnt   = HALF_C;
        h_nxt.st    = H_LEAD;
      end
    end
    // Register reads, answered next cycle
    if (rd)
    begin
      if (addr == srl_pkg::HOST_CTRL)
      begin
        h_nxt.rdata = {25'h0, h_r.tail, 1'b0, h_r.len};
      end
      else if (addr == srl_pkg::HOST_STATUS)
      begin
        h_nxt.rdata = {23'h0, h_r.frames, h_r.st != H_IDLE};
      end
      else if ((addr >= srl_pkg::HOST_BYTE0) && (addr < srl_pkg::HOST_STATUS) &&
               (addr[1:0] == 2'h0))
      begin
        h_nxt.rdata = {24'h0, h_r.bytes[bsel[1:0]]};
      end
    end
    // Sequencer
    if (h_r.st != H_IDLE)
    begin
      h_nxt.cnt = h_r.cnt - 8'h01;
    end
    if (h_r.cnt == 8'h00)
    begin
      case (h_r.st)
        // Rising sck after the setup time or a low half
        H_LEAD, H_LOW:
        begin
          h_nxt.sck = 1'b1;
          h_nxt.cnt = HALF_C;
          h_nxt.st  = H_HIGH;
        end
        // Falling sck: next bit out, MSB first
        H_HIGH:
        begin
          h_nxt.sck   = 1'b0;
          h_nxt.shreg = {h_r.shreg[30:0], 1'b0};
          h_nxt.si    = h_r.shreg[30];
          h_nxt.bits  = h_r.bits - 6'h01;
          h_nxt.cnt   = HALF_C;
          h_nxt.st    = (h_r.bits == 6'h01) ? H_TRAIL : H_LOW;
        end
        // Hold then release select with sck low
        H_TRAIL:
        begin
          h_nxt.cs_n = 1'b1;
          h_nxt.si   = 1'b0;
          h_nxt.cnt  = GAP_C;
          h_nxt.st   = H_GAP;
        end
        // Select stays high long enough for the device to judge
        H_GAP:
        begin
          h_nxt.frames = h_r.frames + 8'h01;
          h_nxt.st     = H_IDLE;
        end
        default: ;
      endcase
    end
  end

  // Host registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_r      <= '0;
      h_r.st   <= H_IDLE;
      h_r.cs_n <= 1'b1;
    end
    else
    begin
      h_r <= h_nxt;
    end
  end

  // Pins and read data from flops
  assign spi.cs_n = h_r.cs_n;
  assign spi.sck  = h_r.sck;
  assign spi.si   = h_r.si;
  assign rdata    = h_r.rdata;

endmodule

`default_nettype wire

//--- rtl/srl_pkg.sv
// Shared constants for the status register write and lock block.
// Assumes both ends and the bench compile this package first.
package srl_pkg;

  // Opcodes seen on the serial input line
  localparam logic [7:0] OP_WR_ONE      = 8'h01;  // Direct write, byte one
  localparam logic [7:0] OP_WR_TWO      = 8'h31;  // Direct write, byte two
  localparam logic [7:0] OP_WR_THREE    = 8'h11;  // Direct write, byte three
  localparam logic [7:0] OP_WR_IND      = 8'h71;  // Indirect write by address
  localparam logic [7:0] OP_LOCK        = 8'h6F;  // Lock the status bytes
  localparam logic [7:0] OP_WREN        = 8'h06;  // Sets write_enable_latch
  localparam logic [7:0] OP_VOLEN       = 8'h50;  // One-shot volatile enable

  // Lock verification bytes, in order
  localparam logic [7:0] LOCK_KEY_FIRST  = 8'h4D;
  localparam logic [7:0] LOCK_KEY_SECOND = 8'h67;

  // Indirect address window
  localparam logic [7:0] IND_ADDR_FIRST = 8'h01;
  localparam logic [7:0] IND_ADDR_LAST  = 8'h05;

  // Status byte layout
  localparam int         NUM_STATUS     = 5;
  localparam int         BYTE_BITS      = 8;
  localparam int         WEL_BIT        = 1;      // write_enable_latch in byte one
  localparam int         PSL_BIT        = 7;      // protect_select_low in byte one
  localparam int         PSH_BIT        = 0;      // protect_select_high in byte two
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  // Host command port offsets
  localparam logic [7:0] HOST_CTRL      = 8'h00;  // Write starts a frame
  localparam logic [7:0] HOST_BYTE0     = 8'h04;  // Frame bytes at 04, 08, 0C, 10
  localparam logic [7:0] HOST_STATUS    = 8'h14;  // Busy and frame count
  localparam int         CTRL_LEN_LSB   = 0;      // Byte count 1..4, 3 bits
  localparam int         CTRL_TAIL_LSB  = 4;      // Extra clocks 0..7, 3 bits
  localparam int         HOST_BYTES     = 4;

  // Host timing in mclk cycles
  localparam int         SCK_HALF_CYC   = 2;      // Half period of the link clock
  localparam int         CS_GAP_CYC     = 8;      // Least time chip select stays high

endpackage

//--- rtl/srl_spi_if.sv
// Serial link between the host end and the device end.
// Assumes single-line SPI mode 0: data sampled on rising sck.
`timescale 1ns/1ps
`default_nettype none

interface srl_spi_if;
  logic cs_n;  // Chip select, active low
  logic sck;   // Link clock, made by the host
  logic si;    // Serial data into the device

  // Device end listens only
  modport dev (input cs_n, input sck, input si);
  // Host end drives everything
  modport host (output cs_n, output sck, output si);
endinterface

`default_nettype wire
